// [rtl/lfw_pkg.sv]
// Package: constants, types and encodings for the freeze/wake controller
`default_nettype none
package lfw_pkg;
	// ----------------------------------------------------------------
	// Service mailbox command bytes
	// ----------------------------------------------------------------
	localparam logic [7:0] LFW_CMD_FREEZE      = 8'hAE;
	localparam logic [7:0] LFW_CMD_SHUTDOWN    = 8'hE0;
	// ----------------------------------------------------------------
	// Option byte field positions
	// ----------------------------------------------------------------
	localparam int         LFW_OPT_FABRIC_BIT  = 0;
	localparam int         LFW_OPT_NVM_BIT     = 1;
	localparam int         LFW_OPT_PLL_BIT     = 2;
	// ----------------------------------------------------------------
	// Per-pin wake role encoding
	// ----------------------------------------------------------------
	localparam logic [1:0] LFW_ROLE_OFF        = 2'h0;
	localparam logic [1:0] LFW_ROLE_CHANGE     = 2'h1;
	localparam logic [1:0] LFW_ROLE_WAKE_HIGH  = 2'h2;
	localparam logic [1:0] LFW_ROLE_WAKE_LOW   = 2'h3;
	// Standby clock select and RAM policy
	localparam logic       LFW_SBY_1MHZ        = 1'b0;
	localparam logic       LFW_SBY_50MHZ       = 1'b1;
	localparam logic       LFW_RAM_SLEEP       = 1'b0;
	localparam logic       LFW_RAM_RETAIN      = 1'b1;
	// Reset value of the pin snapshot
	localparam logic       LFW_SNAP_RST        = 1'b0;
	// ----------------------------------------------------------------
	// Sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		LFW_IDLE,
		LFW_GET_OPT,
		LFW_ANNOUNCE,
		LFW_DISABLE,
		LFW_FROZEN,
		LFW_EXIT
	} lfw_state_e;
endpackage : lfw_pkg
`default_nettype wire

// [rtl/lfw_pin_if.sv]
// Interface: pin snapshot and wake evaluation signals between top and matcher
`timescale 1ns/1ps
`default_nettype none
interface lfw_pin_if #(parameter int N = 8);
	logic [N-1:0]   pin;
	logic [2*N-1:0] role;
	logic           capture;
	logic           armed;
	logic [N-1:0]   snap;
	logic           wake;
	modport ctrl (output pin, output role, output capture, output armed, input snap, input wake);
	modport match (input pin, input role, input capture, input armed, output snap, output wake);
endinterface : lfw_pin_if
`default_nettype wire

// [rtl/lfw_wake_match.sv]
// Module: per-pin snapshot and combined activity/signature wake condition
`timescale 1ns/1ps
`default_nettype none
module lfw_wake_match
	import lfw_pkg::*;
#(
	parameter int N = 8
) (
	input  wire logic clk_i,
	input  wire logic rstn_i,
	lfw_pin_if.match  pif
);
	logic [N-1:0] snap_ff;
	logic [N-1:0] act_w;
	logic [N-1:0] sig_ok_w;
	logic [N-1:0] is_sig_w;
	logic         wake_ff;
	logic         act_any_w;
	logic         sig_all_w;

	function automatic logic [1:0] role_of(input logic [2*N-1:0] r, input int i);
		role_of = r[2*i +: 2];
	endfunction

	genvar g;
	generate
		for (g = 0; g < N; g++) begin : g_pin
			// Any difference from the snapshot, either direction
			assign act_w[g]    = (role_of(pif.role, g) == LFW_ROLE_CHANGE) && (pif.pin[g] != snap_ff[g]);
			assign is_sig_w[g] = (role_of(pif.role, g) == LFW_ROLE_WAKE_HIGH) ||
			                     (role_of(pif.role, g) == LFW_ROLE_WAKE_LOW);
			// Static match level; non-signature pins count as matched
			assign sig_ok_w[g] = (role_of(pif.role, g) == LFW_ROLE_WAKE_HIGH) ? pif.pin[g] :
			                     (role_of(pif.role, g) == LFW_ROLE_WAKE_LOW)  ? ~pif.pin[g] : 1'b1;
		end
	endgenerate

	// OFF pins are excluded entirely
	assign act_any_w = |act_w;
	// An empty signature set must not wake on its own
	assign sig_all_w = (|is_sig_w) && (&sig_ok_w);

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			snap_ff <= {N{LFW_SNAP_RST}};
			wake_ff <= 1'b0;
		end else begin
			if (pif.capture) begin
				snap_ff <= pif.pin;
			end
			wake_ff <= pif.armed && (sig_all_w || act_any_w);
		end
	end

	assign pif.snap = snap_ff;
	assign pif.wake = wake_ff;
endmodule : lfw_wake_match
`default_nettype wire

// [rtl/lfw_ctrl.sv]
// Top: freeze entry sequencer, resource disables, pin hold and wake exit control
`timescale 1ns/1ps
`default_nettype none
module lfw_ctrl
	import lfw_pkg::*;
#(
	parameter int N_PINS = 8
) (
	input  wire logic              clk_i,
	input  wire logic              rstn_i,
	// Service mailbox, request side
	input  wire logic              req_valid_i,
	input  wire logic [7:0]        req_byte_i,
	output logic                   req_abort_o,
	// Service mailbox, toward processor
	output logic                   mbx_valid_o,
	output logic [7:0]             mbx_byte_o,
	input  wire logic              mbx_ready_i,
	// Configuration
	input  wire logic              ram_policy_i,
	input  wire logic              sby_clk_sel_i,
	input  wire logic [2*N_PINS-1:0] pin_role_i,
	input  wire logic [N_PINS-1:0] pin_hold_i,
	// Pins
	input  wire logic [N_PINS-1:0] pin_in_i,
	input  wire logic [N_PINS-1:0] pin_out_i,
	input  wire logic [N_PINS-1:0] pin_oe_i,
	output logic [N_PINS-1:0]      pad_out_o,
	output logic [N_PINS-1:0]      pad_oe_o,
	// Counter wakeup
	input  wire logic              rtc_wake_i,
	input  wire logic              rtc_wake_set_i,
	output logic                   rtc_irq_sysctl_o,
	output logic                   rtc_irq_fabric_o,
	output logic                   rtc_irq_nic_o,
	// Resource controls and status
	output logic                   fabric_off_o,
	output logic                   nvm_off_o,
	output logic                   pll_off_o,
	output logic                   ram_pwr_off_o,
	output logic                   sby_clk_sel_o,
	output logic                   frozen_o,
	output logic                   busy_o,
	output logic                   wake_done_o
);
	lfw_state_e        state_ff, nxt_state;
	logic [2:0]        opt_ff;
	logic [2:0]        nxt_opt;
	logic              req_abort_ff;
	logic              mbx_valid_ff;
	logic              rtc_irq_ff;
	logic [N_PINS-1:0] pad_out_ff;
	logic [N_PINS-1:0] pad_oe_ff;
	logic              fabric_off_ff;
	logic              nvm_off_ff;
	logic              pll_off_ff;
	logic              ram_off_ff;
	logic              sby_ff;
	logic              frozen_ff;
	logic              busy_ff;
	logic              wake_done_ff;

	logic              start_w;
	logic              abort_w;
	logic              exit_w;
	logic              counter_wake_w;
	logic [N_PINS-1:0] non_wake_w;
	logic [N_PINS-1:0] nxt_pad_out;
	logic [N_PINS-1:0] nxt_pad_oe;

	lfw_pin_if #(.N(N_PINS)) pif ();

	function automatic logic is_wake_pin(input logic [2*N_PINS-1:0] r, input int i);
		is_wake_pin = (r[2*i +: 2] != LFW_ROLE_OFF);
	endfunction

	// ----------------------------------------------------------------
	// Request decode
	// ----------------------------------------------------------------
	assign start_w = req_valid_i && (req_byte_i == LFW_CMD_FREEZE) && (state_ff == LFW_IDLE);
	// Anything arriving after the option byte is refused, not queued
	assign abort_w = req_valid_i && (state_ff != LFW_IDLE) && (state_ff != LFW_GET_OPT);
	// Counter wakeup from the event or the software set bit
	assign counter_wake_w = rtc_wake_i || rtc_wake_set_i;
	assign exit_w = pif.wake || counter_wake_w;

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	always_comb begin
		nxt_state = state_ff;
		nxt_opt   = opt_ff;
		case (state_ff)
			LFW_IDLE: begin
				if (start_w) begin
					nxt_state = LFW_GET_OPT;
				end
			end
			LFW_GET_OPT: begin
				if (req_valid_i) begin
					nxt_opt   = {req_byte_i[LFW_OPT_PLL_BIT], req_byte_i[LFW_OPT_NVM_BIT],
					             req_byte_i[LFW_OPT_FABRIC_BIT]};
					nxt_state = LFW_ANNOUNCE;
				end
			end
			LFW_ANNOUNCE: begin
				if (mbx_valid_ff && mbx_ready_i) begin
					nxt_state = LFW_DISABLE;
				end
			end
			LFW_DISABLE: begin
				nxt_state = LFW_FROZEN;
			end
			LFW_FROZEN: begin
				if (exit_w) begin
					nxt_state = LFW_EXIT;
				end
			end
			LFW_EXIT: begin
				nxt_state = LFW_IDLE;
			end
			default: begin
				nxt_state = LFW_IDLE;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Pin hold during freeze
	// ----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < N_PINS; g++) begin : g_pad
			assign non_wake_w[g] = !is_wake_pin(pin_role_i, g);
		end
	endgenerate
	// Non-wake hold pins freeze their last driven value, others float
	assign nxt_pad_out = (nxt_state == LFW_FROZEN) ? pad_out_ff : pin_out_i;
	assign nxt_pad_oe  = (nxt_state == LFW_FROZEN) ? (pad_oe_ff & pin_hold_i & non_wake_w) : pin_oe_i;

	// Snapshot taken while disabling, one cycle before the freeze begins
	assign pif.pin     = pin_in_i;
	assign pif.role    = pin_role_i;
	assign pif.capture = (state_ff == LFW_DISABLE);
	assign pif.armed   = (state_ff == LFW_FROZEN);

	lfw_wake_match #(.N(N_PINS)) u_match (
		.clk_i  (clk_i),
		.rstn_i (rstn_i),
		.pif    (pif)
	);

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			state_ff     <= LFW_IDLE;
			opt_ff       <= '0;
			req_abort_ff <= 1'b0;
			mbx_valid_ff <= 1'b0;
			rtc_irq_ff   <= 1'b0;
			pad_out_ff   <= '0;
			pad_oe_ff    <= '0;
			frozen_ff    <= 1'b0;
			busy_ff      <= 1'b0;
			wake_done_ff <= 1'b0;
		end else begin
			state_ff     <= nxt_state;
			opt_ff       <= nxt_opt;
			req_abort_ff <= abort_w;
			// Byte stays offered until the FIFO takes it
			mbx_valid_ff <= (nxt_state == LFW_ANNOUNCE);
			rtc_irq_ff   <= counter_wake_w;
			pad_out_ff   <= nxt_pad_out;
			pad_oe_ff    <= nxt_pad_oe;
			frozen_ff    <= (nxt_state == LFW_FROZEN);
			busy_ff      <= (nxt_state != LFW_IDLE);
			wake_done_ff <= (state_ff == LFW_FROZEN) && exit_w;
		end
	end

	// Resource controls: asserted from disable until exit; the standby clock select is loaded at disable and not released at exit
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			fabric_off_ff <= 1'b0;
			nvm_off_ff    <= 1'b0;
			pll_off_ff    <= 1'b0;
			ram_off_ff    <= 1'b0;
			sby_ff        <= LFW_SBY_1MHZ;
		end else if (nxt_state == LFW_DISABLE) begin
			fabric_off_ff <= opt_ff[LFW_OPT_FABRIC_BIT];
			nvm_off_ff    <= opt_ff[LFW_OPT_NVM_BIT];
			pll_off_ff    <= opt_ff[LFW_OPT_PLL_BIT];
			// Sleep policy drops fabric RAM supply; contents lost
			ram_off_ff    <= (ram_policy_i == LFW_RAM_SLEEP);
			sby_ff        <= sby_clk_sel_i;
		end else if (nxt_state == LFW_EXIT) begin
			// Only controls are released; no state is cleared, so exit is fast
			fabric_off_ff <= 1'b0;
			nvm_off_ff    <= 1'b0;
			pll_off_ff    <= 1'b0;
			ram_off_ff    <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign req_abort_o      = req_abort_ff;
	assign mbx_valid_o      = mbx_valid_ff;
	assign mbx_byte_o       = LFW_CMD_SHUTDOWN;
	assign rtc_irq_sysctl_o = rtc_irq_ff;
	assign rtc_irq_fabric_o = rtc_irq_ff;
	assign rtc_irq_nic_o    = rtc_irq_ff;
	assign pad_out_o        = pad_out_ff;
	assign pad_oe_o         = pad_oe_ff;
	assign fabric_off_o     = fabric_off_ff;
	assign nvm_off_o        = nvm_off_ff;
	assign pll_off_o        = pll_off_ff;
	assign ram_pwr_off_o    = ram_off_ff;
	assign sby_clk_sel_o    = sby_ff;
	assign frozen_o         = frozen_ff;
	assign busy_o           = busy_ff;
	assign wake_done_o      = wake_done_ff;
endmodule : lfw_ctrl
`default_nettype wire

// [test/lfw_ctrl_asserts.sv]
// Checker: port-level assertions for the freeze/wake controller
`timescale 1ns/1ps
`default_nettype none
module lfw_ctrl_asserts
	import lfw_pkg::*;
#(parameter int N_PINS = 8) (
	input wire logic              clk_i,
	input wire logic              rstn_i,
	input wire logic              req_valid_i,
	input wire logic              req_abort_o,
	input wire logic              mbx_valid_o,
	input wire logic [7:0]        mbx_byte_o,
	input wire logic              mbx_ready_i,
	input wire logic              ram_policy_i,
	input wire logic              sby_clk_sel_i,
	input wire logic              rtc_wake_i,
	input wire logic              rtc_wake_set_i,
	input wire logic              rtc_irq_sysctl_o,
	input wire logic              rtc_irq_fabric_o,
	input wire logic              rtc_irq_nic_o,
	input wire logic              ram_pwr_off_o,
	input wire logic              sby_clk_sel_o,
	input wire logic              frozen_o,
	input wire logic              wake_done_o,
	input wire logic [N_PINS-1:0] pad_out_o,
	input wire logic [N_PINS-1:0] pad_oe_o
);
	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	a_shutdown_byte: assert property (mbx_valid_o |-> mbx_byte_o == LFW_CMD_SHUTDOWN) else $error("bad byte");
	a_stall_hold: assert property (mbx_valid_o && !mbx_ready_i |=> mbx_valid_o && !frozen_o) else $error("no stall");
	a_busy_abort: assert property (req_valid_i && (frozen_o || mbx_valid_o) |=> req_abort_o) else $error("no abort");
	a_entry_time: assert property (mbx_valid_o && mbx_ready_i |-> ##2 frozen_o) else $error("late freeze");
	a_ram_sby_set: assert property (mbx_valid_o && mbx_ready_i |=> ram_pwr_off_o == ($past(ram_policy_i) == LFW_RAM_SLEEP)
		&& sby_clk_sel_o == $past(sby_clk_sel_i)) else $error("bad ram or clock");
	a_irq_route: assert property ((rtc_wake_i || rtc_wake_set_i) |=> rtc_irq_sysctl_o && rtc_irq_fabric_o && rtc_irq_nic_o)
		else $error("irq not routed");
	a_rtc_exit: assert property (frozen_o && rtc_wake_i |=> wake_done_o) else $error("no counter exit");
	a_single_exit: assert property ($fell(frozen_o) |-> wake_done_o ##1 !wake_done_o [*4]) else $error("bad exit");
	a_pad_hold: assert property (frozen_o && $past(frozen_o) |-> $stable(pad_out_o) && $stable(pad_oe_o))
		else $error("pads moved");
	c_stalled: cover property (mbx_valid_o && !mbx_ready_i ##1 mbx_ready_i);
	c_abort: cover property (req_abort_o);
	c_exit: cover property ($fell(frozen_o));
endmodule // lfw_ctrl_asserts
bind lfw_ctrl lfw_ctrl_asserts #(.N_PINS(N_PINS)) lfw_ctrl_asserts_inst (.clk_i(clk_i), .rstn_i(rstn_i),
	.req_valid_i(req_valid_i), .req_abort_o(req_abort_o), .mbx_valid_o(mbx_valid_o), .mbx_byte_o(mbx_byte_o),
	.mbx_ready_i(mbx_ready_i), .ram_policy_i(ram_policy_i), .sby_clk_sel_i(sby_clk_sel_i), .rtc_wake_i(rtc_wake_i),
	.rtc_wake_set_i(rtc_wake_set_i), .rtc_irq_sysctl_o(rtc_irq_sysctl_o), .rtc_irq_fabric_o(rtc_irq_fabric_o),
	.rtc_irq_nic_o(rtc_irq_nic_o), .ram_pwr_off_o(ram_pwr_off_o), .sby_clk_sel_o(sby_clk_sel_o),
	.frozen_o(frozen_o), .wake_done_o(wake_done_o), .pad_out_o(pad_out_o), .pad_oe_o(pad_oe_o));
`default_nettype wire

// [test/lfw_mbx_model.sv]
// Partner: processor-side mailbox FIFO that takes the shutdown byte after a set stall
`timescale 1ns/1ps
`default_nettype none
module lfw_mbx_model (
	input  wire logic       clk_i,
	input  wire logic       rstn_i,
	input  wire logic       valid_i,
	input  wire logic [7:0] byte_i,
	input  wire logic [7:0] stall_i,
	output logic            ready_o,
	output logic [7:0]      byte_o,
	output logic [7:0]      wait_o
);
	logic [7:0] cnt;
	// Ready is withheld for stall_i plus one offered cycles, as a full FIFO would do
	always @(posedge clk_i) begin
		if (!rstn_i) begin
			ready_o <= #1 1'b0;
			byte_o <= #1 8'h00;
			wait_o <= #1 8'h00;
			cnt <= #1 8'h00;
		end else if (valid_i && ready_o) begin
			ready_o <= #1 1'b0;
			byte_o <= #1 byte_i;
			wait_o <= #1 cnt;
			cnt <= #1 8'h00;
		end else if (valid_i) begin
			ready_o <= #1 (cnt >= stall_i);
			cnt <= #1 cnt + 8'h01;
		end
	end
endmodule // lfw_mbx_model
`default_nettype wire

// [test/lfw_ctrl_tb.sv]
// Testbench: freeze entry, abort, pin and counter wake scenarios
`timescale 1ns/1ps
`default_nettype none
module lfw_ctrl_tb;
	import lfw_pkg::*;
	logic clk_i = 1'b0, rstn_i = 1'b0, req_valid_i = 1'b0, ram_policy_i = 1'b0, sby_clk_sel_i = 1'b0;
	logic rtc_wake_i = 1'b0, rtc_wake_set_i = 1'b0;
	logic [7:0] req_byte_i = 8'h00, stall = 8'h00, pin_hold_i = 8'h00, pin_in_i = 8'h00;
	logic [7:0] pin_out_i = 8'h00, pin_oe_i = 8'h00;
	logic [15:0] pin_role_i = 16'h0000;
	logic req_abort_o, mbx_valid_o, mbx_ready_i, rtc_irq_sysctl_o, rtc_irq_fabric_o, rtc_irq_nic_o;
	logic fabric_off_o, nvm_off_o, pll_off_o, ram_pwr_off_o, sby_clk_sel_o, frozen_o, busy_o, wake_done_o;
	logic [7:0] mbx_byte_o, pad_out_o, pad_oe_o, got_byte, got_wait;
	int fails = 0, checked = 0;
	lfw_ctrl #(.N_PINS(8)) lfw_ctrl_inst (.clk_i(clk_i), .rstn_i(rstn_i), .req_valid_i(req_valid_i),
		.req_byte_i(req_byte_i), .req_abort_o(req_abort_o), .mbx_valid_o(mbx_valid_o), .mbx_byte_o(mbx_byte_o),
		.mbx_ready_i(mbx_ready_i), .ram_policy_i(ram_policy_i), .sby_clk_sel_i(sby_clk_sel_i), .pin_role_i(pin_role_i),
		.pin_hold_i(pin_hold_i), .pin_in_i(pin_in_i), .pin_out_i(pin_out_i), .pin_oe_i(pin_oe_i), .pad_out_o(pad_out_o),
		.pad_oe_o(pad_oe_o), .rtc_wake_i(rtc_wake_i), .rtc_wake_set_i(rtc_wake_set_i), .rtc_irq_sysctl_o(rtc_irq_sysctl_o),
		.rtc_irq_fabric_o(rtc_irq_fabric_o), .rtc_irq_nic_o(rtc_irq_nic_o), .fabric_off_o(fabric_off_o),
		.nvm_off_o(nvm_off_o), .pll_off_o(pll_off_o), .ram_pwr_off_o(ram_pwr_off_o), .sby_clk_sel_o(sby_clk_sel_o),
		.frozen_o(frozen_o), .busy_o(busy_o), .wake_done_o(wake_done_o));
	lfw_mbx_model lfw_mbx_model_inst (.clk_i(clk_i), .rstn_i(rstn_i), .valid_i(mbx_valid_o), .byte_i(mbx_byte_o),
		.stall_i(stall), .ready_o(mbx_ready_i), .byte_o(got_byte), .wait_o(got_wait));
	always #2.5 clk_i = ~clk_i;
	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	task automatic results();
		if (fails == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic freeze(input logic [2:0] opt, input logic [7:0] st);
		stall = st;
		req_valid_i = 1'b1;
		req_byte_i = LFW_CMD_FREEZE;
		step(1);
		req_byte_i = {5'h00, opt};
		step(1);
		req_valid_i = 1'b0;
		for (int i = 0; i < 30 && frozen_o !== 1'b1; i++)
			step(1);
		chk("frozen", 8'h01, 8'(frozen_o));
		chk("shutdown byte", LFW_CMD_SHUTDOWN, got_byte);
		chk("stall wait", st + 8'h01, got_wait);
		chk("offs", 8'(opt), {5'h00, pll_off_o, nvm_off_o, fabric_off_o});
		chk("ram off", 8'(ram_policy_i == LFW_RAM_SLEEP), 8'(ram_pwr_off_o));
		chk("sby clk", 8'(sby_clk_sel_i), 8'(sby_clk_sel_o));
	endtask
	task automatic wake();
		int k;
		k = 0;
		while (wake_done_o !== 1'b1 && k < 3) begin
			step(1);
			k++;
		end
		chk("wake done", 8'h01, 8'(wake_done_o));
		chk("offs clear", 8'h00, {4'h0, frozen_o, fabric_off_o, nvm_off_o, pll_off_o});
		step(1);
		chk("done pulse", 8'h00, 8'(wake_done_o));
	endtask
	task automatic t_change();
		pin_role_i = {12'h000, LFW_ROLE_CHANGE, LFW_ROLE_CHANGE};
		pin_in_i = 8'h5A;
		ram_policy_i = LFW_RAM_RETAIN;
		freeze(3'h5, 8'h00);
		pin_in_i[0] = 1'b1;
		wake();
		ram_policy_i = LFW_RAM_SLEEP;
		sby_clk_sel_i = LFW_SBY_50MHZ;
		freeze(3'h2, 8'h03);
		pin_in_i[1] = 1'b0;
		wake();
	endtask
	task automatic t_sig();
		pin_role_i = {8'h00, LFW_ROLE_WAKE_LOW, LFW_ROLE_WAKE_HIGH, 4'h0};
		pin_in_i = 8'h5A;
		pin_out_i = 8'hF0;
		pin_oe_i = 8'hFF;
		pin_hold_i = 8'h30;
		freeze(3'h7, 8'h01);
		pin_out_i = 8'h00;
		pin_in_i[4] = 1'b0;
		step(6);
		chk("pads oe", 8'h30, pad_oe_o);
		chk("pads out", 8'h30, pad_out_o & pad_oe_o);
		pin_in_i[2] = 1'b1;
		step(6);
		chk("partial match", 8'h01, 8'(frozen_o));
		req_valid_i = 1'b1;
		req_byte_i = LFW_CMD_FREEZE;
		step(1);
		req_valid_i = 1'b0;
		chk("abort", 8'h01, 8'(req_abort_o));
		pin_in_i[3] = 1'b0;
		wake();
	endtask
	task automatic t_rtc();
		pin_role_i = 16'h0000;
		freeze(3'h1, 8'h00);
		// Counter stays clocked and times out while frozen
		rtc_wake_i = 1'b1;
		step(1);
		chk("irqs", 8'h07, {5'h00, rtc_irq_sysctl_o, rtc_irq_fabric_o, rtc_irq_nic_o});
		wake();
		rtc_wake_i = 1'b0;
		freeze(3'h4, 8'h02);
		rtc_wake_set_i = 1'b1;
		wake();
		rtc_wake_set_i = 1'b0;
	endtask
	initial begin
		step(8);
		rstn_i = 1'b1;
		chk("idle outs", 8'h00, {frozen_o, busy_o, mbx_valid_o, fabric_off_o, pll_off_o, ram_pwr_off_o, pad_oe_o[1:0]});
		t_change();
		t_sig();
		t_rtc();
		results();
	end
	// Generous bound: the scenarios need fewer than a hundred cycles
	initial begin
		#20000;
		fails++;
		results();
	end
endmodule // lfw_ctrl_tb
`default_nettype wire
